//--- rtl/match_timer_regs.vh
/*
  register map, field positions, reset values and divider codes of the
  compare-match interval timer.
  assumes a 32-bit axi4-lite slave with one register per aligned word.
*/
`ifndef MATCH_TIMER_REGS_VH
`define MATCH_TIMER_REGS_VH

// ==========================================================
// register byte offsets
`define OFS_START        4'h0
`define OFS_CTRL_STATUS  4'h4
`define OFS_COUNTER      4'h8
`define OFS_CONSTANT     4'hc

// ==========================================================
// field positions
`define BIT_RUN          0
`define BIT_FLAG         7
`define BIT_IRQ_ENABLE   6
`define BIT_CKS_HI       1
`define BIT_CKS_LO       0

// ==========================================================
// reset values
`define RST_COUNTER      16'h0000
`define RST_CONSTANT     16'hffff
`define RST_CKS          2'h0

// ==========================================================
// clock-select codes and prescale divisors
`define CKS_DIV_A        2'h0
`define CKS_DIV_4        2'h1
`define CKS_DIV_C        2'h2
`define DIV_A            8'h08
`define DIV_4            8'h04
`define DIV_C            8'h20
`define DIV_D            8'h80

// ==========================================================
// axi responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

//--- rtl/match_timer.v
/*
  compare-match interval timer with an axi4-lite register port.
  assumes one clock (aclk) and a synchronous active-low reset; the
  prescaled count rate is a one-cycle enable, never a second clock.
*/
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
// Summary of operation
// - with the run bit set, counter steps once per selected prescale tick.
// - counter equal to the constant clears the counter to zero.
// - every compare match sets the match flag to one.
// - clock-select code 01 counts at the peripheral clock divided by four.
// - control/status holds match flag, interrupt enable and clock select.
`timescale 1ns/1ps
`include "match_timer_regs.vh"

module match_timer #(
  parameter WIDTH = 16
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // write address channel
  input  wire [3:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  // write data channel
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  // write response channel
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // read address channel
  input  wire [3:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  // read data channel
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // interrupt
  output wire        irq
);

  // ==========================================================
  // registers
  // timer state
  reg             count_run;
  reg [1:0]       clock_select;
  reg             irq_enable;
  reg             match_flag;
  reg             irq_mask;
  reg [WIDTH-1:0] match_counter;
  reg [WIDTH-1:0] match_constant;
  reg [7:0]       prescale;
  // write halves are held until both are in; one write in flight
  reg             aw_held;
  reg [3:0]       aw_addr;
  reg             w_held;
  reg [31:0]      w_data;
  reg [3:0]       w_strb;

  // ==========================================================
  // prescaler
  function [7:0] divisor;
    input [1:0] sel;
    begin
      case (sel)
        `CKS_DIV_A: divisor = `DIV_A;
        `CKS_DIV_4: divisor = `DIV_4;
        `CKS_DIV_C: divisor = `DIV_C;
        default:    divisor = `DIV_D;
      endcase
    end
  endfunction

  // tick is a one-cycle enable; the prescaler stops with the run bit so
  // the first count after a start always takes a full period
  wire [7:0] last_step = divisor(clock_select) - 8'h01;
  // >= rather than == so that a switch to a faster rate while running
  // ends the current period at once instead of wrapping the prescaler
  wire       tick      = count_run && (prescale >= last_step);

  always @(posedge aclk) begin
    if (!aresetn || !count_run || tick) begin
      prescale <= 8'h00;
    end else begin
      prescale <= prescale + 8'h01;
    end
  end

  // ==========================================================
  // counter and compare
  wire hit = tick && (match_counter == match_constant);

  // ==========================================================
  // axi4-lite write path
  assign awready = !aw_held;
  assign wready  = !w_held;
  wire do_write  = aw_held && w_held && !bvalid;
  wire sel_start = do_write && aw_addr == `OFS_START;
  wire sel_ctrl  = do_write && aw_addr == `OFS_CTRL_STATUS;
  wire sel_cnt   = do_write && aw_addr == `OFS_COUNTER;
  wire sel_const = do_write && aw_addr == `OFS_CONSTANT;
  wire mapped    = sel_start || sel_ctrl || sel_cnt || sel_const;
  // low address bits are ignored, so with a 4-bit address every word
  // is mapped; slverr stays only as a guard should the map shrink
  // flag clears by writing a one to it; a match in the same cycle wins
  wire flag_clr  = sel_ctrl && w_strb[0] && w_data[`BIT_FLAG];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
    end else begin
      if (awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= {awaddr[3:2], 2'b00};
      end
      if (wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      // both halves held: execute now, answer stands from the next cycle
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      count_run      <= 1'b0;
      clock_select   <= `RST_CKS;
      irq_enable     <= 1'b0;
      match_flag     <= 1'b0;
      match_counter  <= `RST_COUNTER;
      match_constant <= `RST_CONSTANT;
    end else begin
      if (sel_start && w_strb[0]) begin
        count_run <= w_data[`BIT_RUN];
      end
      if (sel_ctrl && w_strb[0]) begin
        irq_enable   <= w_data[`BIT_IRQ_ENABLE];
        clock_select <= w_data[`BIT_CKS_HI:`BIT_CKS_LO];
      end
      if (sel_const) begin
        if (w_strb[0]) match_constant[7:0]  <= w_data[7:0];
        if (w_strb[1]) match_constant[15:8] <= w_data[15:8];
      end
      if (hit) begin
        match_flag <= 1'b1;
      end else if (flag_clr) begin
        match_flag <= 1'b0;
      end
      // a software write to the counter takes priority over counting
      // the prescaler phase is kept, so a write does not delay the tick
      if (sel_cnt && (w_strb[0] || w_strb[1])) begin
        if (w_strb[0]) match_counter[7:0]  <= w_data[7:0];
        if (w_strb[1]) match_counter[15:8] <= w_data[15:8];
      end else if (hit) begin
        match_counter <= `RST_COUNTER;
      end else if (tick) begin
        match_counter <= match_counter + 16'h0001;
      end
      // no tick while run is low, so the counter holds
    end
  end

  // ==========================================================
  // interrupt: status flag gated by the enable (acts as the mask)
  // only one event source, so no separate mask register is kept
  always @* irq_mask = irq_enable;
  assign irq = match_flag && irq_mask;

  // ==========================================================
  // axi4-lite read path
  // a new read is refused while the answer stands; one read at a time
  assign arready = !rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `RESP_OKAY;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rresp  <= `RESP_OKAY;
      // data latched at the address handshake, stands until rready
      case ({araddr[3:2], 2'b00})
        `OFS_START:
          rdata <= {31'h0000_0000, count_run};
        `OFS_CTRL_STATUS:
          rdata <= {24'h00_0000, match_flag, irq_enable, 4'h0,
                    clock_select};
        `OFS_COUNTER:
          rdata <= {16'h0000, match_counter};
        `OFS_CONSTANT:
          rdata <= {16'h0000, match_constant};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

//--- testbench/match_timer_assertions.sv
/*
  port checker for the compare-match timer.
  assumes it is bound to match_timer with one clock.
*/
`timescale 1ns/1ps
module match_timer_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  // read channels
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  // write response and interrupt
  input wire logic bvalid,
  input wire logic bready,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // sequences
  sequence ar_take;
    arvalid && arready;
  endsequence
  sequence r_wait;
    rvalid && !rready;
  endsequence
  sequence aw_take;
    awvalid && awready;
  endsequence
  sequence w_take;
    wvalid && wready;
  endsequence
  a_read_answer: assert property (ar_take |=> rvalid)
    else $error("no read answer");
  a_read_holds: assert property (r_wait |=> rvalid)
    else $error("read answer dropped");
  a_ar_refused: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
  a_write_holds: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer dropped");
  a_irq_drop: assert property ($fell(irq) |-> ##[0:1] bvalid)
    else $error("irq fell without a write");
  a_irq_reset: assert property ($rose(aresetn) |-> !irq)
    else $error("irq high out of reset");
  a_read_clear: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer not withdrawn");
  a_write_clear: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer not withdrawn");
  a_aw_refused: assert property (aw_take |=> !awready)
    else $error("second write address taken");
  a_w_refused: assert property (w_take |=> !wready)
    else $error("second write data taken");
  a_write_answer: assert property (
    aw_take ##0 w_take ##0 !bvalid |-> ##2 bvalid)
    else $error("no write answer");
endmodule
bind match_timer match_timer_chk chk_i (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .wready, .arvalid, .arready, .rvalid, .rready,
  .bvalid, .bready, .irq);

//--- testbench/tb.sv
/*
  self-checking bench for match_timer over axi4-lite.
  assumes match_timer_regs.vh on the include path.
*/
`timescale 1ns/1ps
`include "match_timer_regs.vh"
module tb;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0;
  logic        bready = 0, arvalid = 0, rready = 0;
  logic [3:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rv, c1;
  logic [1:0]  rs;
  logic [1:0]  bs;
  logic [3:0]  wstrb = 4'hf;
  logic [3:0]  ws = 4'hf;
  wire         awready, wready, bvalid, arready, rvalid, irq;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          num_errors = 0, samples_checked = 0;
  logic [7:0]  dv [4] = '{`DIV_A, `DIV_4, `DIV_C, `DIV_D};
  match_timer uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq);
  initial forever #25 aclk = ~aclk;
  // ==========
  // tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task summarize;
    $display("checked %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= ws;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bs = bresp;
    bready <= 0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rv = rdata;
    rs = rresp;
    rready <= 0;
  endtask
  // ==========
  // tests
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd(`OFS_CONSTANT);
    chk(rv, 32'h0000_ffff);
    rd(`OFS_CTRL_STATUS);
    chk(rv, 32'h0000_0000);
    // low address bits are ignored: 0x2 reads the start word
    rd(4'h2);
    chk(rs, `RESP_OKAY);
    chk(rv, 32'h0000_0000);
    // a low-byte strobe only touches bits 7:0 of the constant
    ws = 4'h1;
    wr(`OFS_CONSTANT, 32'h0000_1234);
    ws = 4'hf;
    chk(bs, `RESP_OKAY);
    rd(`OFS_CONSTANT);
    chk(rv, 32'h0000_ff34);
    wr(`OFS_COUNTER, 32'h0000_0005);
    repeat (20) @(posedge aclk);
    rd(`OFS_COUNTER);
    chk(rv, 32'h0000_0005);
    // two reads 128 cycles apart see 128/divisor ticks
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_CTRL_STATUS, k);
      wr(`OFS_START, 32'h0000_0001);
      rd(`OFS_COUNTER);
      c1 = rv;
      repeat (125) @(posedge aclk);
      rd(`OFS_COUNTER);
      wr(`OFS_START, 32'h0000_0000);
      chk(rv - c1, 128 / dv[k]);
    end
    wr(`OFS_COUNTER, 32'h0000_0000);
    wr(`OFS_CONSTANT, 32'h0000_0000);
    wr(`OFS_CTRL_STATUS, 32'h0000_0001);
    wr(`OFS_START, 32'h0000_0001);
    repeat (20) @(posedge aclk);
    rd(`OFS_COUNTER);
    chk(rv, 32'h0000_0000);
    rd(`OFS_CTRL_STATUS);
    chk(rv, 32'h0000_0081);
    chk(irq, 0);
    wr(`OFS_START, 32'h0000_0000);
    wr(`OFS_CTRL_STATUS, 32'h0000_0041);
    chk(irq, 1);
    wr(`OFS_CTRL_STATUS, 32'h0000_00c1);
    chk(irq, 0);
    rd(`OFS_CTRL_STATUS);
    chk(rv, 32'h0000_0041);
    // matches go on setting the flag after it was cleared
    wr(`OFS_START, 32'h0000_0001);
    repeat (10) @(posedge aclk);
    rd(`OFS_CTRL_STATUS);
    chk(rv, 32'h0000_00c1);
    chk(irq, 1);
    // reset in mid-run, with the timer running and the irq high
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(`OFS_CONSTANT);
    chk(rv, 32'h0000_ffff);
    rd(`OFS_START);
    chk(rv, 32'h0000_0000);
    rd(`OFS_CTRL_STATUS);
    chk(rv, 32'h0000_0000);
    chk(irq, 0);
    summarize();
  end
  // a hung handshake ends here
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    summarize();
  end
endmodule
